//--- bioc_pkg.sv
// constants, register map and types for the batch i/o output control block
package bioc_pkg;
    // clock and timing
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned PULSE_WIDTH_MS = 10;
    localparam int unsigned MAX_PULSE_RATE = 49;
    localparam int unsigned SEC_NS = 1000000000;
    localparam int unsigned PULSE_WIDTH_CYC = PULSE_WIDTH_MS * 1000000 / CLK_PERIOD_NS;
    // least spacing rounds up so the rate never exceeds the maximum
    localparam int unsigned PULSE_PERIOD_CYC =
        (SEC_NS + MAX_PULSE_RATE * CLK_PERIOD_NS - 1) / (MAX_PULSE_RATE * CLK_PERIOD_NS);
    localparam int unsigned SEC_CYC = SEC_NS / CLK_PERIOD_NS;
    localparam int unsigned DELAY_MAX_MIN = 79;
    localparam int unsigned DELAY_MAX_SEC_PART = 59;
    localparam logic [12:0] DELAY_MAX_S = 13'(DELAY_MAX_MIN * 60 + DELAY_MAX_SEC_PART);

    // bus geometry
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned QTY_W = 24;
    localparam int unsigned RES_W = 16;

    // register offsets (word index)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_DELAY = 4'h1;
    localparam logic [3:0] REG_PRESET = 4'h2;
    localparam logic [3:0] REG_PRESTOP = 4'h3;
    localparam logic [3:0] REG_RESOL = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    localparam logic [3:0] REG_DELIV = 4'h6;
    localparam logic [3:0] REG_TOTAL = 4'h7;
    localparam logic [3:0] REG_PEND = 4'h8;

    // control register fields
    localparam int unsigned CTRL_PRESET = 0;
    localparam int unsigned CTRL_QUAD = 1;
    localparam int unsigned CTRL_PCHK = 2;
    localparam int unsigned CTRL_REMFN = 3;
    localparam int unsigned CTRL_EXENC = 4;
    localparam int unsigned CTRL_R2EN = 5;
    localparam int unsigned CTRL_SSTART = 6;
    localparam int unsigned CTRL_SSTOP = 7;
    localparam int unsigned CTRL_CH1T = 8;
    localparam int unsigned CTRL_CH2T = 11;
    localparam int unsigned CTRL_W = 14;
    localparam logic [13:0] CTRL_RST = 14'h0000;
    localparam logic [12:0] DELAY_RST = 13'h0000;
    localparam logic [23:0] QTY_RST = 24'h000000;
    localparam logic [15:0] RESOL_RST = 16'h0001;

    // error codes shown while a quadrature alarm stands
    localparam logic [4:0] ERR_NONE = 5'h00;
    localparam logic [4:0] ERR_MISSING = 5'd13;
    localparam logic [4:0] ERR_SIMUL = 5'd18;

    // input front-end types
    typedef enum logic [2:0] {
        IN_LOGIC = 3'b000,
        IN_OPENC = 3'b001,
        IN_NAMUR = 3'b010,
        IN_CONTACT = 3'b011,
        IN_COIL = 3'b100
    } bioc_intype_t;

    // delivery sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_SLOW = 2'b10,
        ST_END = 2'b11
    } bioc_state_t;
endpackage

//--- bioc_pulse_gen.sv
// rate-limited total output pulse generator with pending queue
`timescale 1ns/10ps
module bioc_pulse_gen #(
    parameter int unsigned CNT_W = 16,
    parameter int unsigned WIDTH_CYC = 2000000,
    parameter int unsigned PERIOD_CYC = 4081633
) (
    input wire logic mclk, // system clock
    input wire logic rst, // async reset, active high
    input wire logic inc, // one total increment
    output logic pulse_n_q, // active-low output pulse
    output logic [CNT_W-1:0] pending_q // increments not yet sent
);
    localparam logic [31:0] PER_M1 = 32'(PERIOD_CYC - 1);
    localparam logic [31:0] HIGH_AT = 32'(PERIOD_CYC - WIDTH_CYC);
    localparam logic [CNT_W-1:0] PEND_MAX = '1;

    logic [31:0] timer_q;
    logic fire;

    assign fire = (timer_q == 32'h0) && ((pending_q != '0) || inc);

    // queue: increments wait here, saturating rather than wrapping
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pending_q <= '0;
        end else if (fire && !inc) begin
            pending_q <= pending_q - 1'b1;
        end else if (inc && !fire && pending_q != PEND_MAX) begin
            pending_q <= pending_q + 1'b1;
        end
    end

    // spacing timer: one pulse per period at most
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            timer_q <= 32'h0;
        end else if (fire) begin
            timer_q <= PER_M1;
        end else if (timer_q != 32'h0) begin
            timer_q <= timer_q - 32'h1;
        end
    end

    // low for the width, then released
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pulse_n_q <= 1'b1;
        end else if (fire) begin
            pulse_n_q <= 1'b0;
        end else if (timer_q == HIGH_AT) begin
            pulse_n_q <= 1'b1;
        end
    end
endmodule // bioc_pulse_gen

//--- bioc_top.sv
// flow input, relay, pulse, end-of-delivery and alarm control of a truck totaliser
// Functional notes
// - channel 1 counts in both modes; channel 2 only checks phase in quadrature
// - contact and coil input types are accepted on channel 1 only
// - remote button does start or stop/print, as configured, like the key
// - calibration switch honoured only when explosion-proof enclosure is configured
// - preset mode drives two relays: single, dual valve or pump
// - second relay waits a programmable 0 to 79:59 after start
// - relays slow the flow once remaining quantity reaches prestop
// - non-preset mode uses relay 1 only, no delay, no prestop
// - one output pulse per least digit increment of the total
// - output pulse is active low, about 10 ms long
// - at most 49 output pulses per second
// - end-of-delivery output on from delivery end until next start
// - in quadrature the flow alarm reports channel discrepancy
// - alarm output low while alarm stands; only a stop event (halt key, or remote in stop mode) clears it
// - alarm on missing pulses or simultaneous pulses since last clear
// - alarm drops both relays, lights halt, keeps counting, shows 13 or 18
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/10ps
module bioc_top #(
    parameter int unsigned SEC_CYC = bioc_pkg::SEC_CYC,
    parameter int unsigned PULSE_WIDTH_CYC = bioc_pkg::PULSE_WIDTH_CYC,
    parameter int unsigned PULSE_PERIOD_CYC = bioc_pkg::PULSE_PERIOD_CYC,
    parameter int unsigned PEND_W = 16
) (
    input wire logic mclk, // system clock, 200 MHz
    input wire logic rst, // async reset, active high
    input wire logic [bioc_pkg::ADDR_W-1:0] addr, // register word index
    input wire logic [bioc_pkg::DATA_W-1:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [bioc_pkg::DATA_W-1:0] rdata_q, // read data, cycle after rd
    input wire logic ch1_in, // flow pulse channel 1 (90 deg)
    input wire logic ch2_in, // flow pulse channel 2 (0 deg)
    input wire logic remote_sw, // remote push-button, high when pressed
    input wire logic cal_sw, // external calibration switch
    input wire logic start_key, // front-panel start/reset key
    input wire logic halt_key, // front-panel stop/print key
    output logic relay1_q, // relay 1 energised
    output logic relay2_q, // relay 2 energised
    output logic pulse_out_n_q, // total output pulse, active low
    output logic eod_n_q, // end of delivery, active low
    output logic alarm_n_q, // flow alarm, active low
    output logic halt_led_q, // halt indicator
    output logic [4:0] err_code_q, // flashing error code, 0 when none
    output logic print_req_q, // one-cycle ticket print request
    output logic cal_active_q, // calibration switch honoured and closed
    output logic [2:0] ch1_type_q, // channel 1 front-end type
    output logic [2:0] ch2_type_q // channel 2 front-end type
);
    logic [bioc_pkg::CTRL_W-1:0] ctrl_q;
    logic [12:0] delay_q;
    logic [bioc_pkg::QTY_W-1:0] preset_q, prestop_q, deliv_q, total_q;
    logic [bioc_pkg::RES_W-1:0] resol_q, prescale_q;
    logic [PEND_W-1:0] pending;
    logic pulse_n;
    bioc_pkg::bioc_state_t state_q;
    logic ch1_p_q, ch2_p_q, rem_p_q, start_p_q, halt_p_q;
    logic ch1_e, ch2_e, rem_e, start_evt, stop_evt;
    logic preset_en, quad_en, chk_en, alarm_q, last_ch1_q, seen_q;
    logic [31:0] sec_cnt_q;
    logic sec_tick;
    logic [12:0] dly_cnt_q;
    logic dly_done;
    logic total_inc;
    logic [bioc_pkg::QTY_W-1:0] remain;
    logic err_miss, err_sim;
    logic [4:0] err_q;
    logic [2:0] w_ch1t, w_ch2t;

    localparam logic [31:0] SEC_M1 = 32'(SEC_CYC - 1);

    assign preset_en = ctrl_q[bioc_pkg::CTRL_PRESET];
    assign quad_en = ctrl_q[bioc_pkg::CTRL_QUAD];
    assign chk_en = quad_en && ctrl_q[bioc_pkg::CTRL_PCHK];
    assign w_ch1t = wdata[bioc_pkg::CTRL_CH1T +: 3];
    assign w_ch2t = wdata[bioc_pkg::CTRL_CH2T +: 3];

    // register writes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_q <= bioc_pkg::CTRL_RST;
            delay_q <= bioc_pkg::DELAY_RST;
            preset_q <= bioc_pkg::QTY_RST;
            prestop_q <= bioc_pkg::QTY_RST;
            resol_q <= bioc_pkg::RESOL_RST;
        end else if (wr) begin
            case (addr)
                bioc_pkg::REG_CTRL: begin
                    ctrl_q[bioc_pkg::CTRL_CH1T-1:0] <= wdata[bioc_pkg::CTRL_CH1T-1:0];
                    if (w_ch1t <= 3'(bioc_pkg::IN_COIL)) begin
                        ctrl_q[bioc_pkg::CTRL_CH1T +: 3] <= w_ch1t;
                    end
                    if (w_ch2t <= 3'(bioc_pkg::IN_NAMUR)) begin
                        ctrl_q[bioc_pkg::CTRL_CH2T +: 3] <= w_ch2t;
                    end
                end
                bioc_pkg::REG_DELAY: begin
                    if (wdata[12:0] > bioc_pkg::DELAY_MAX_S) begin
                        delay_q <= bioc_pkg::DELAY_MAX_S;
                    end else begin
                        delay_q <= wdata[12:0];
                    end
                end
                bioc_pkg::REG_PRESET: preset_q <= wdata[bioc_pkg::QTY_W-1:0];
                bioc_pkg::REG_PRESTOP: prestop_q <= wdata[bioc_pkg::QTY_W-1:0];
                bioc_pkg::REG_RESOL: resol_q <= wdata[bioc_pkg::RES_W-1:0];
                default: ;
            endcase
        end
    end

    // read port, data in the cycle after the strobe
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (rd) begin
            case (addr)
                bioc_pkg::REG_CTRL: rdata_q <= 32'(ctrl_q);
                bioc_pkg::REG_DELAY: rdata_q <= 32'(delay_q);
                bioc_pkg::REG_PRESET: rdata_q <= 32'(preset_q);
                bioc_pkg::REG_PRESTOP: rdata_q <= 32'(prestop_q);
                bioc_pkg::REG_RESOL: rdata_q <= 32'(resol_q);
                bioc_pkg::REG_STATUS: rdata_q <= {19'h0, err_code_q, cal_active_q, halt_led_q,
                    ~alarm_n_q, ~eod_n_q, relay2_q, relay1_q, state_q};
                bioc_pkg::REG_DELIV: rdata_q <= 32'(deliv_q);
                bioc_pkg::REG_TOTAL: rdata_q <= 32'(total_q);
                bioc_pkg::REG_PEND: rdata_q <= 32'(pending);
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    // previous input levels for rising-edge detection
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ch1_p_q <= 1'b0;
            ch2_p_q <= 1'b0;
            rem_p_q <= 1'b0;
            start_p_q <= 1'b0;
            halt_p_q <= 1'b0;
        end else begin
            ch1_p_q <= ch1_in;
            ch2_p_q <= ch2_in;
            rem_p_q <= remote_sw;
            start_p_q <= start_key;
            halt_p_q <= halt_key;
        end
    end

    assign ch1_e = ch1_in && !ch1_p_q;
    assign ch2_e = quad_en && ch2_in && !ch2_p_q;
    assign rem_e = remote_sw && !rem_p_q;
    assign start_evt = (start_key && !start_p_q) ||
        (rem_e && !ctrl_q[bioc_pkg::CTRL_REMFN]);
    assign stop_evt = (halt_key && !halt_p_q) ||
        (rem_e && ctrl_q[bioc_pkg::CTRL_REMFN]);

    // calibration switch gate
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cal_active_q <= 1'b0;
        end else begin
            cal_active_q <= ctrl_q[bioc_pkg::CTRL_EXENC] && cal_sw;
        end
    end

    // front-end type outputs
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ch1_type_q <= 3'(bioc_pkg::IN_LOGIC);
            ch2_type_q <= 3'(bioc_pkg::IN_LOGIC);
        end else begin
            ch1_type_q <= ctrl_q[bioc_pkg::CTRL_CH1T +: 3];
            ch2_type_q <= ctrl_q[bioc_pkg::CTRL_CH2T +: 3];
        end
    end

    // prescaler: channel 1 pulses per least digit of the total
    assign total_inc = ch1_e && ((prescale_q + 1'b1 >= resol_q) || resol_q == '0);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prescale_q <= '0;
        end else if (total_inc) begin
            prescale_q <= '0;
        end else if (ch1_e) begin
            prescale_q <= prescale_q + 1'b1;
        end
    end

    // accumulated and delivered totals, counted even during an alarm
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            total_q <= '0;
            deliv_q <= '0;
        end else begin
            if (total_inc) begin
                total_q <= total_q + 1'b1;
            end
            if (start_evt && (state_q == bioc_pkg::ST_IDLE || state_q == bioc_pkg::ST_END)) begin
                deliv_q <= '0;
            end else if (total_inc && state_q != bioc_pkg::ST_IDLE) begin
                deliv_q <= deliv_q + 1'b1;
            end
        end
    end

    // quadrature check: missing and simultaneous pulses
    assign err_sim = chk_en && ch1_e && ch2_e;
    assign err_miss = chk_en && seen_q && ((ch1_e && !ch2_e && last_ch1_q) ||
        (ch2_e && !ch1_e && !last_ch1_q));
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            last_ch1_q <= 1'b0;
            seen_q <= 1'b0;
        end else if (!chk_en || (stop_evt && alarm_q)) begin
            seen_q <= 1'b0;
        end else if (ch1_e != ch2_e) begin
            last_ch1_q <= ch1_e;
            seen_q <= 1'b1;
        end
    end

    // sticky alarm; a new error wins over the stop-event clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            alarm_q <= 1'b0;
            err_q <= bioc_pkg::ERR_NONE;
        end else if (err_sim || err_miss) begin
            alarm_q <= 1'b1;
            if (!alarm_q || stop_evt) begin
                err_q <= err_sim ? bioc_pkg::ERR_SIMUL : bioc_pkg::ERR_MISSING;
            end
        end else if (stop_evt) begin
            alarm_q <= 1'b0;
            err_q <= bioc_pkg::ERR_NONE;
        end
    end

    // remaining quantity to the batch end
    assign remain = (deliv_q >= preset_q) ? '0 : preset_q - deliv_q;

    // delivery sequencer
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= bioc_pkg::ST_IDLE;
        end else begin
            case (state_q)
                bioc_pkg::ST_IDLE, bioc_pkg::ST_END: begin
                    if (start_evt) begin
                        state_q <= bioc_pkg::ST_RUN;
                    end
                end
                bioc_pkg::ST_RUN: begin
                    if (stop_evt || (preset_en && remain == '0)) begin
                        state_q <= bioc_pkg::ST_END;
                    end else if (preset_en && remain <= prestop_q) begin
                        state_q <= bioc_pkg::ST_SLOW;
                    end
                end
                bioc_pkg::ST_SLOW: begin
                    if (stop_evt || !preset_en || remain == '0) begin
                        state_q <= bioc_pkg::ST_END;
                    end
                end
                default: state_q <= bioc_pkg::ST_IDLE;
            endcase
        end
    end

    // one-second tick for the start delay
    assign sec_tick = (sec_cnt_q == SEC_M1);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sec_cnt_q <= 32'h0;
        end else if (sec_tick || state_q != bioc_pkg::ST_RUN) begin
            sec_cnt_q <= 32'h0;
        end else begin
            sec_cnt_q <= sec_cnt_q + 32'h1;
        end
    end

    // start delay counter, reloaded while not running
    assign dly_done = !ctrl_q[bioc_pkg::CTRL_SSTART] || (dly_cnt_q == 13'h0);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dly_cnt_q <= 13'h0;
        end else if (state_q != bioc_pkg::ST_RUN && state_q != bioc_pkg::ST_SLOW) begin
            dly_cnt_q <= delay_q;
        end else if (sec_tick && dly_cnt_q != 13'h0) begin
            dly_cnt_q <= dly_cnt_q - 13'h1;
        end
    end

    // relay drive
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            relay1_q <= 1'b0;
            relay2_q <= 1'b0;
        end else begin
            relay1_q <= !alarm_q && (state_q == bioc_pkg::ST_RUN ||
                state_q == bioc_pkg::ST_SLOW);
            relay2_q <= !alarm_q && preset_en && ctrl_q[bioc_pkg::CTRL_R2EN] && dly_done &&
                (state_q == bioc_pkg::ST_RUN || (state_q == bioc_pkg::ST_SLOW &&
                !ctrl_q[bioc_pkg::CTRL_SSTOP]));
        end
    end

    // end of delivery, alarm, code, halt and print outputs
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            eod_n_q <= 1'b1;
            alarm_n_q <= 1'b1;
            err_code_q <= bioc_pkg::ERR_NONE;
            halt_led_q <= 1'b0;
            print_req_q <= 1'b0;
        end else begin
            eod_n_q <= !(state_q == bioc_pkg::ST_END);
            alarm_n_q <= !alarm_q;
            err_code_q <= err_q;
            halt_led_q <= alarm_q || state_q == bioc_pkg::ST_END;
            print_req_q <= stop_evt;
        end
    end

    // rate-limited pulse output
    bioc_pulse_gen #(
        .CNT_W(PEND_W),
        .WIDTH_CYC(PULSE_WIDTH_CYC),
        .PERIOD_CYC(PULSE_PERIOD_CYC)
    ) u_pulse (
        .mclk(mclk),
        .rst(rst),
        .inc(total_inc),
        .pulse_n_q(pulse_n),
        .pending_q(pending)
    );

    // output pulse retimed so the port comes from a local flip-flop
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pulse_out_n_q <= 1'b1;
        end else begin
            pulse_out_n_q <= pulse_n;
        end
    end
endmodule // bioc_top

//--- bioc_top_properties.sv
// port assertions for the batch i/o output control block
`timescale 1ns/10ps
module bioc_top_properties #(
    parameter int unsigned PULSE_WIDTH_CYC = 4,
    parameter int unsigned PULSE_PERIOD_CYC = 10
) (
    input logic mclk, // clock
    input logic rst, // reset
    input logic rd, // read strobe
    input logic [bioc_pkg::DATA_W-1:0] rdata_q, // read data
    input logic cal_sw, // cal switch
    input logic start_key, // start key
    input logic halt_key, // halt key
    input logic remote_sw, // remote button
    input logic relay1_q, // relay 1
    input logic relay2_q, // relay 2
    input logic pulse_out_n_q, // output pulse
    input logic eod_n_q, // end of delivery
    input logic alarm_n_q, // flow alarm
    input logic halt_led_q, // halt indicator
    input logic [4:0] err_code_q, // error code
    input logic print_req_q, // print request
    input logic cal_active_q, // cal honoured
    input logic [2:0] ch1_type_q, // channel 1 type
    input logic [2:0] ch2_type_q // channel 2 type
);
    int unsigned low_cnt, gap_cnt;
    logic [3:0] stop_hist, go_hist;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // pulse length, spacing since last fall, recent key history
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            low_cnt <= 0;
            gap_cnt <= 1000;
            stop_hist <= 4'h0;
            go_hist <= 4'h0;
        end else begin
            low_cnt <= pulse_out_n_q ? 0 : low_cnt + 1;
            gap_cnt <= $fell(pulse_out_n_q) ? 1 : gap_cnt + 1;
            stop_hist <= {stop_hist[2:0], halt_key | remote_sw};
            go_hist <= {go_hist[2:0], start_key | remote_sw};
        end
    end
    a_pulse_width: assert property ($rose(pulse_out_n_q) |-> low_cnt == PULSE_WIDTH_CYC)
        else $error("pulse width wrong");
    a_pulse_gap: assert property ($fell(pulse_out_n_q) |-> gap_cnt >= PULSE_PERIOD_CYC)
        else $error("pulses too close");
    a_alarm_relays: assert property (!alarm_n_q |-> !relay1_q && !relay2_q)
        else $error("relay on during alarm");
    a_alarm_shows: assert property (!alarm_n_q |-> halt_led_q
        && (err_code_q == 5'h0d || err_code_q == 5'h12)) else $error("alarm display wrong");
    a_alarm_clear: assert property ($rose(alarm_n_q) |-> |stop_hist)
        else $error("alarm cleared without halt");
    a_eod_clear: assert property ($rose(eod_n_q) |-> |go_hist)
        else $error("eod dropped without start");
    a_cal_gate: assert property (cal_active_q |-> $past(cal_sw))
        else $error("cal active without switch");
    a_ch_types: assert property (ch1_type_q <= 3'h4 && ch2_type_q <= 3'h2)
        else $error("illegal channel type");
    a_read_idle: assert property (!$past(rd) |-> rdata_q == '0)
        else $error("stray read data");
    a_print_short: assert property (print_req_q |=> !print_req_q)
        else $error("print request too long");
    c_pulse: cover property ($fell(pulse_out_n_q));
    c_alarm: cover property ($fell(alarm_n_q));
    c_relay2: cover property ($rose(relay2_q));
    c_eod: cover property ($fell(eod_n_q));
endmodule // bioc_top_properties

bind bioc_top bioc_top_properties #(
    .PULSE_WIDTH_CYC(PULSE_WIDTH_CYC), .PULSE_PERIOD_CYC(PULSE_PERIOD_CYC)
) bioc_top_properties_inst (
    .mclk, .rst, .rd, .rdata_q, .cal_sw, .start_key, .halt_key, .remote_sw, .relay1_q,
    .relay2_q, .pulse_out_n_q, .eod_n_q, .alarm_n_q, .halt_led_q, .err_code_q,
    .print_req_q, .cal_active_q, .ch1_type_q, .ch2_type_q
);

//--- bioc_flow_src.sv
// flowmeter sensor model driving the two pulse channels
`timescale 1ns/10ps
module bioc_flow_src (
    input logic mclk, // clock
    input logic rst, // reset
    input logic [1:0] fire, // pulse request, bit1 ch2, bit0 ch1
    output logic ch1_in, // channel 1, 90 deg
    output logic ch2_in // channel 2, 0 deg
);
    logic [1:0] cnt1_q;
    logic [1:0] cnt2_q;
    // each request gives a three-cycle pulse
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt1_q <= 2'h0;
            cnt2_q <= 2'h0;
        end else begin
            cnt1_q <= fire[0] ? 2'h3 : cnt1_q - 2'(cnt1_q != 2'h0);
            cnt2_q <= fire[1] ? 2'h3 : cnt2_q - 2'(cnt2_q != 2'h0);
        end
    end
    assign ch1_in = cnt1_q != 2'h0;
    assign ch2_in = cnt2_q != 2'h0;
endmodule // bioc_flow_src

//--- bioc_top_bench.sv
// self-checking bench for the batch i/o output control block
`timescale 1ns/10ps
module bioc_top_bench;
    logic mclk, rst, wr, rd, remote_sw, cal_sw, start_key, halt_key;
    logic ch1_in, ch2_in, relay1_q, relay2_q, pulse_out_n_q, eod_n_q, alarm_n_q;
    logic halt_led_q, print_req_q, cal_active_q;
    logic [bioc_pkg::ADDR_W-1:0] addr;
    logic [bioc_pkg::DATA_W-1:0] wdata, rdata_q;
    logic [1:0] fire;
    logic [4:0] err_code_q;
    logic [2:0] ch1_type_q, ch2_type_q;
    int errors = 0, checks_done = 0, npulse = 0;
    bioc_top #(.SEC_CYC(20), .PULSE_WIDTH_CYC(4), .PULSE_PERIOD_CYC(10), .PEND_W(16))
    bioc_top_inst (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata_q, .ch1_in, .ch2_in,
        .remote_sw, .cal_sw, .start_key, .halt_key, .relay1_q, .relay2_q, .pulse_out_n_q,
        .eod_n_q, .alarm_n_q, .halt_led_q, .err_code_q, .print_req_q, .cal_active_q,
        .ch1_type_q, .ch2_type_q);
    bioc_flow_src bioc_flow_src_inst (.mclk, .rst, .fire, .ch1_in, .ch2_in);
    // clock generator
    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end
    // count output pulses
    always @(negedge pulse_out_n_q) npulse++;
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task wreg(input logic [3:0] a, logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge mclk);
        wr <= 1'h0;
    endtask
    task rchk(input logic [3:0] a, logic [31:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'h1;
        @(posedge mclk);
        rd <= 1'h0;
        #1;
        chk(rdata_q, exp);
    endtask
    // k bits: 0 start, 1 halt, 2 remote
    task press(input logic [2:0] k);
        @(posedge mclk);
        {remote_sw, halt_key, start_key} <= k;
        @(posedge mclk);
        {remote_sw, halt_key, start_key} <= 3'h0;
        cyc(3);
    endtask
    // n pulses eight cycles apart
    task flow(input logic [1:0] f, int n);
        repeat (n) begin
            @(posedge mclk);
            fire <= f;
            @(posedge mclk);
            fire <= 2'h0;
            cyc(6);
        end
    endtask
    task wait_pulses(input int exp);
        for (int i = 0; i < 300 && npulse < exp; i++) @(posedge mclk);
        if (npulse < exp) begin
            errors++;
            tally_and_finish();
        end
        cyc(30);
    endtask
    task t_reset;
        chk(relay1_q, 1'h0);
        chk(eod_n_q, 1'h1);
        chk(alarm_n_q, 1'h1);
        rchk(bioc_pkg::REG_CTRL, 32'h0);
        rchk(bioc_pkg::REG_RESOL, 32'h1);
        rchk(4'hf, 32'h0);
        @(posedge mclk);
        #1;
        chk(rdata_q, 32'h0);
        $display("test reset done");
    endtask
    task t_types_cal;
        cal_sw <= 1'h1;
        cyc(3);
        chk(cal_active_q, 1'h0);
        wreg(bioc_pkg::REG_CTRL, 32'h1410);
        cyc(3);
        chk(cal_active_q, 1'h1);
        chk(ch1_type_q, 3'h4);
        chk(ch2_type_q, 3'h2);
        wreg(bioc_pkg::REG_CTRL, 32'h1d00);
        cyc(3);
        chk(cal_active_q, 1'h0);
        chk(ch1_type_q, 3'h4);
        chk(ch2_type_q, 3'h2);
        cal_sw <= 1'h0;
        $display("test types done");
    endtask
    task t_preset;
        npulse = 0;
        wreg(bioc_pkg::REG_CTRL, 32'he1);
        wreg(bioc_pkg::REG_DELAY, 32'h1);
        wreg(bioc_pkg::REG_PRESET, 32'h4);
        wreg(bioc_pkg::REG_PRESTOP, 32'h2);
        press(3'h1);
        chk(relay1_q, 1'h1);
        chk(relay2_q, 1'h0);
        cyc(25);
        chk(relay2_q, 1'h1);
        flow(2'h1, 2);
        chk(relay1_q, 1'h1);
        chk(relay2_q, 1'h0);
        rchk(bioc_pkg::REG_STATUS, 32'h6);
        flow(2'h1, 2);
        chk(relay1_q, 1'h0);
        chk(eod_n_q, 1'h0);
        wait_pulses(4);
        chk(npulse, 4);
        rchk(bioc_pkg::REG_PEND, 32'h0);
        rchk(bioc_pkg::REG_TOTAL, 32'h4);
        chk(eod_n_q, 1'h0);
        $display("test preset done");
    endtask
    task t_nonpreset;
        npulse = 0;
        wreg(bioc_pkg::REG_CTRL, 32'h20);
        press(3'h4);
        chk(relay1_q, 1'h1);
        chk(eod_n_q, 1'h1);
        cyc(30);
        chk(relay2_q, 1'h0);
        flow(2'h2, 2);
        chk(alarm_n_q, 1'h1);
        flow(2'h1, 3);
        chk(relay1_q, 1'h1);
        press(3'h2);
        chk(relay1_q, 1'h0);
        chk(eod_n_q, 1'h0);
        wait_pulses(3);
        chk(npulse, 3);
        $display("test non-preset done");
    endtask
    task t_quad;
        wreg(bioc_pkg::REG_CTRL, 32'he);
        press(3'h1);
        flow(2'h3, 1);
        chk(alarm_n_q, 1'h0);
        chk(err_code_q, 5'h12);
        chk(relay1_q, 1'h0);
        chk(halt_led_q, 1'h1);
        flow(2'h1, 1);
        rchk(bioc_pkg::REG_TOTAL, 32'h9);
        cyc(20);
        chk(alarm_n_q, 1'h0);
        press(3'h2);
        chk(alarm_n_q, 1'h1);
        press(3'h1);
        flow(2'h1, 2);
        chk(err_code_q, 5'h0d);
        press(3'h4);
        chk(alarm_n_q, 1'h1);
        chk(err_code_q, 5'h0);
        $display("test quad done");
    endtask
    // reset, then the scenarios in turn
    initial begin
        rst = 1'h1;
        {wr, rd, remote_sw, cal_sw, start_key, halt_key, fire, addr, wdata} = '0;
        cyc(3);
        rst <= 1'h0;
        t_reset();
        t_types_cal();
        t_preset();
        t_nonpreset();
        t_quad();
        tally_and_finish();
    end
endmodule // bioc_top_bench
